// >>> core/irb_cmp.sv
// Eight-bit compare: register minus operand, giving N, Z and C
`timescale 1ns/1ns
module irb_cmp (
    input wire logic [7:0] reg_val,
    input wire logic [7:0] operand,
    output logic neg,
    output logic zero,
    output logic carry
);

    logic [8:0] diff;

    // ********************************************
    // Subtract with borrow out
    // ********************************************
    always_comb begin
        diff = {1'b0, reg_val} - {1'b0, operand};
        neg = diff[7];
        zero = (diff[7:0] == 8'h00);
        // Carry is set when no borrow, i.e. register >= operand
        carry = ~diff[8];
    end

endmodule

// >>> core/irb_cond.sv
// Branch condition evaluator working from the status flags
`timescale 1ns/1ns
module irb_cond
    import irb_pkg::*;
(
    input wire irb_op_type op,
    input wire logic [7:0] status,
    output logic is_branch,
    output logic taken
);

    // ********************************************
    // Condition select
    // ********************************************
    always_comb begin
        is_branch = 1'b1;
        taken = 1'b0;
        case (op)
            IRB_OP_BR_NOT_ZERO: taken = ~status[IRB_FLAG_Z];
            IRB_OP_BR_ZERO: taken = status[IRB_FLAG_Z];
            IRB_OP_BR_CARRY_CLR: taken = ~status[IRB_FLAG_C];
            IRB_OP_BR_CARRY_SET: taken = status[IRB_FLAG_C];
            IRB_OP_BR_MINUS: taken = status[IRB_FLAG_N];
            IRB_OP_BR_PLUS: taken = ~status[IRB_FLAG_N];
            IRB_OP_BR_OVF_CLR: taken = ~status[IRB_FLAG_V];
            IRB_OP_BR_OVF_SET: taken = status[IRB_FLAG_V];
            default: is_branch = 1'b0;
        endcase
    end

endmodule

// >>> core/irb_core.sv
// Index register, transfer, stack and branch execution unit
`timescale 1ns/1ns

module irb_core
    import irb_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire irb_instr_type instr,
    input wire logic instr_valid,
    input wire logic [7:0] mem_rdata,
    input wire logic mem_rvalid,
    output irb_mem_req_type mem_req,
    output logic busy,
    output logic [15:0] pc,
    output logic [7:0] acc,
    output logic [7:0] index_x,
    output logic [7:0] index_y,
    output logic [7:0] stack_ptr,
    output logic [7:0] status
);

    typedef enum logic [2:0] {
        IRB_ST_IDLE,
        IRB_ST_READ,
        IRB_ST_PUSH_HI,
        IRB_ST_PUSH_LO,
        IRB_ST_WRITE
    } irb_state_type;

    // ********************************************
    // Helpers
    // ********************************************
    function automatic logic [7:0] step(input logic [7:0] v,
                                        input logic up);
        // Plain modulo-256 arithmetic: no saturation at either end
        step = up ? 8'(v + 8'h01) : 8'(v - 8'h01);
    endfunction

    function automatic logic [7:0] nz(input logic [7:0] st,
                                      input logic [7:0] v);
        nz = st;
        nz[IRB_FLAG_N] = v[7];
        nz[IRB_FLAG_Z] = (v == 8'h00);
    endfunction

    function automatic logic [15:0] stack_addr(input logic [7:0] sp);
        stack_addr = {IRB_STACK_PAGE, sp};
    endfunction

    // ********************************************
    // State
    // ********************************************
    irb_state_type state_q, state_d;
    irb_op_type op_q, op_d;
    logic [15:0] pc_q, pc_d;
    logic [15:0] tgt_q, tgt_d;
    logic [15:0] ret_q, ret_d;
    logic [7:0] a_q, a_d;
    logic [7:0] x_q, x_d;
    logic [7:0] y_q, y_d;
    logic [7:0] sp_q, sp_d;
    logic [7:0] p_q, p_d;
    irb_mem_req_type req_q, req_d;
    logic busy_q, busy_d;

    logic is_branch;
    logic taken;
    logic [7:0] cmp_lhs;
    logic [7:0] cmp_rhs;
    logic cmp_n, cmp_z, cmp_c;
    logic [15:0] seq_pc;
    logic [15:0] br_pc;

    irb_cond u_cond (
        .op(instr.op),
        .status(p_q),
        .is_branch(is_branch),
        .taken(taken)
    );

    irb_cmp u_cmp (
        .reg_val(cmp_lhs),
        .operand(cmp_rhs),
        .neg(cmp_n),
        .zero(cmp_z),
        .carry(cmp_c)
    );

    // Compare sources follow the op held for a memory read, else the new op
    always_comb begin
        if (state_q == IRB_ST_READ) begin
            cmp_lhs = (op_q == IRB_OP_CMP_Y) ? y_q : x_q;
            cmp_rhs = mem_rdata;
        end else begin
            cmp_lhs = (instr.op == IRB_OP_CMP_Y) ? y_q : x_q;
            cmp_rhs = instr.imm;
        end
    end

    // Sign-extended offset from the address after the branch
    always_comb begin
        seq_pc = 16'(pc_q + IRB_BRANCH_LEN);
        br_pc = 16'(seq_pc + {{8{instr.imm[7]}}, instr.imm});
    end

    // ********************************************
    // Next-state logic
    // ********************************************
    always_comb begin
        state_d = state_q;
        op_d = op_q;
        pc_d = pc_q;
        tgt_d = tgt_q;
        ret_d = ret_q;
        a_d = a_q;
        x_d = x_q;
        y_d = y_q;
        sp_d = sp_q;
        p_d = p_q;
        req_d = '0;
        case (state_q)
            IRB_ST_IDLE: begin
                if (instr_valid) begin
                    op_d = instr.op;
                    pc_d = 16'(pc_q + IRB_ONE_LEN);
                    if (is_branch) begin
                        // Untaken branch only advances past itself
                        pc_d = taken ? br_pc : seq_pc;
                    end
                    case (instr.op)
                        IRB_OP_INCR_X: begin
                            x_d = step(x_q, 1'b1);
                            p_d = nz(p_q, x_d);
                        end
                        IRB_OP_DECR_X: begin
                            x_d = step(x_q, 1'b0);
                            p_d = nz(p_q, x_d);
                        end
                        IRB_OP_INCR_Y: begin
                            y_d = step(y_q, 1'b1);
                            p_d = nz(p_q, y_d);
                        end
                        IRB_OP_DECR_Y: begin
                            y_d = step(y_q, 1'b0);
                            p_d = nz(p_q, y_d);
                        end
                        IRB_OP_CMP_X, IRB_OP_CMP_Y: begin
                            if (instr.imm_sel) begin
                                pc_d = seq_pc;
                                p_d[IRB_FLAG_N] = cmp_n;
                                p_d[IRB_FLAG_Z] = cmp_z;
                                p_d[IRB_FLAG_C] = cmp_c;
                            end else begin
                                pc_d = 16'(pc_q + IRB_CALL_LEN);
                                req_d.rd = 1'b1;
                                req_d.addr = instr.addr;
                                state_d = IRB_ST_READ;
                            end
                        end
                        IRB_OP_CALL: begin
                            // Return points at the call's last byte
                            ret_d = 16'(pc_q + IRB_BRANCH_LEN);
                            tgt_d = instr.addr;
                            pc_d = pc_q;
                            req_d.wr = 1'b1;
                            req_d.addr = stack_addr(sp_q);
                            req_d.wdata = ret_d[15:8];
                            sp_d = 8'(sp_q - 8'h01);
                            state_d = IRB_ST_PUSH_LO;
                        end
                        IRB_OP_JUMP: begin
                            pc_d = instr.addr;
                        end
                        IRB_OP_X_TO_ACC: begin
                            a_d = x_q;
                            p_d = nz(p_q, x_q);
                        end
                        IRB_OP_SP_TO_X: begin
                            x_d = sp_q;
                            p_d = nz(p_q, sp_q);
                        end
                        IRB_OP_X_TO_SP: begin
                            sp_d = x_q;
                        end
                        IRB_OP_PUSH_STATUS, IRB_OP_PUSH_ACC: begin
                            req_d.wr = 1'b1;
                            req_d.addr = stack_addr(sp_q);
                            req_d.wdata = (instr.op == IRB_OP_PUSH_ACC)
                                ? a_q : p_q;
                            sp_d = 8'(sp_q - 8'h01);
                        end
                        IRB_OP_PULL_STATUS, IRB_OP_PULL_ACC: begin
                            sp_d = 8'(sp_q + 8'h01);
                            req_d.rd = 1'b1;
                            req_d.addr = stack_addr(sp_d);
                            state_d = IRB_ST_READ;
                        end
                        IRB_OP_SET_IRQ_DIS: begin
                            p_d[IRB_FLAG_I] = 1'b1;
                        end
                        IRB_OP_CLR_IRQ_DIS: begin
                            p_d[IRB_FLAG_I] = 1'b0;
                        end
                        IRB_OP_INCR_MEM, IRB_OP_DECR_MEM: begin
                            pc_d = 16'(pc_q + IRB_CALL_LEN);
                            tgt_d = instr.addr;
                            req_d.rd = 1'b1;
                            req_d.addr = instr.addr;
                            state_d = IRB_ST_READ;
                        end
                        default: begin
                        end
                    endcase
                end
            end
            IRB_ST_READ: begin
                req_d = req_q;
                if (mem_rvalid) begin
                    req_d = '0;
                    state_d = IRB_ST_IDLE;
                    case (op_q)
                        IRB_OP_CMP_X, IRB_OP_CMP_Y: begin
                            p_d[IRB_FLAG_N] = cmp_n;
                            p_d[IRB_FLAG_Z] = cmp_z;
                            p_d[IRB_FLAG_C] = cmp_c;
                        end
                        IRB_OP_PULL_ACC: begin
                            a_d = mem_rdata;
                            p_d = nz(p_q, mem_rdata);
                        end
                        IRB_OP_PULL_STATUS: begin
                            p_d = mem_rdata;
                        end
                        IRB_OP_INCR_MEM, IRB_OP_DECR_MEM: begin
                            req_d.wr = 1'b1;
                            req_d.addr = tgt_q;
                            req_d.wdata = step(mem_rdata,
                                op_q == IRB_OP_INCR_MEM);
                            p_d = nz(p_q, req_d.wdata);
                            state_d = IRB_ST_WRITE;
                        end
                        default: begin
                        end
                    endcase
                end
            end
            IRB_ST_PUSH_LO: begin
                req_d.wr = 1'b1;
                req_d.addr = stack_addr(sp_q);
                req_d.wdata = ret_q[7:0];
                sp_d = 8'(sp_q - 8'h01);
                state_d = IRB_ST_PUSH_HI;
            end
            IRB_ST_PUSH_HI: begin
                // Control moves only after both return bytes are stacked
                pc_d = tgt_q;
                state_d = IRB_ST_IDLE;
            end
            IRB_ST_WRITE: begin
                state_d = IRB_ST_IDLE;
            end
            default: begin
                state_d = IRB_ST_IDLE;
            end
        endcase
        // Busy is registered so the pin comes straight from a flop
        busy_d = (state_d != IRB_ST_IDLE);
    end

    // ********************************************
    // Registers
    // ********************************************
    always_ff @(posedge mclk) begin
        if (reset) begin
            state_q <= IRB_ST_IDLE;
            op_q <= IRB_OP_NOP;
            pc_q <= IRB_RST_PC;
            tgt_q <= IRB_RST_PC;
            ret_q <= IRB_RST_PC;
            a_q <= IRB_RST_REG;
            x_q <= IRB_RST_REG;
            y_q <= IRB_RST_REG;
            sp_q <= IRB_RST_SP;
            p_q <= IRB_RST_STATUS;
            req_q <= '0;
            busy_q <= 1'b0;
        end else begin
            state_q <= state_d;
            op_q <= op_d;
            pc_q <= pc_d;
            tgt_q <= tgt_d;
            ret_q <= ret_d;
            a_q <= a_d;
            x_q <= x_d;
            y_q <= y_d;
            sp_q <= sp_d;
            p_q <= p_d;
            req_q <= req_d;
            busy_q <= busy_d;
        end
    end

    assign mem_req = req_q;
    assign busy = busy_q;
    assign pc = pc_q;
    assign acc = a_q;
    assign index_x = x_q;
    assign index_y = y_q;
    assign stack_ptr = sp_q;
    assign status = p_q;

    // ********************************************
    // Checks
    // ********************************************
    property p_incr_x_wrap;
        @(posedge mclk) disable iff (reset)
        (!busy && instr_valid && instr.op == IRB_OP_INCR_X)
        |=> (x_q == 8'($past(x_q) + 8'h01));
    endproperty
    a_incr_x_wrap: assert property (p_incr_x_wrap)
        else $error("X increment did not wrap");

    property p_decr_x_wrap;
        @(posedge mclk) disable iff (reset)
        (!busy && instr_valid && instr.op == IRB_OP_DECR_X && x_q == 8'h00)
        |=> (x_q == IRB_BYTE_MAX) && p_q[IRB_FLAG_N] && !p_q[IRB_FLAG_Z];
    endproperty
    a_decr_x_wrap: assert property (p_decr_x_wrap)
        else $error("X decrement at zero did not give FF");

    property p_decr_y;
        @(posedge mclk) disable iff (reset)
        (!busy && instr_valid && instr.op == IRB_OP_DECR_Y)
        |=> (y_q == 8'($past(y_q) - 8'h01));
    endproperty
    a_decr_y: assert property (p_decr_y)
        else $error("Y decrement wrong");

    property p_branch_pc;
        @(posedge mclk) disable iff (reset)
        (!busy && instr_valid && is_branch)
        |=> pc_q == 16'($past(pc_q) + IRB_BRANCH_LEN
            + ($past(taken) ? {{8{$past(instr.imm[7])}}, $past(instr.imm)}
            : 16'h0000));
    endproperty
    a_branch_pc: assert property (p_branch_pc)
        else $error("Branch target wrong");

    property p_branch_quiet;
        @(posedge mclk) disable iff (reset)
        (!busy && instr_valid && is_branch)
        |=> x_q == $past(x_q) && p_q == $past(p_q) && !mem_req.wr;
    endproperty
    a_branch_quiet: assert property (p_branch_quiet)
        else $error("Branch had a side effect");

    property p_jump;
        @(posedge mclk) disable iff (reset)
        (!busy && instr_valid && instr.op == IRB_OP_JUMP)
        |=> pc_q == $past(instr.addr) && sp_q == $past(sp_q);
    endproperty
    a_jump: assert property (p_jump)
        else $error("Jump wrong");

    sequence s_call_push;
        mem_req.wr ##1 mem_req.wr ##1 !mem_req.wr;
    endsequence
    property p_call;
        @(posedge mclk) disable iff (reset)
        (!busy && instr_valid && instr.op == IRB_OP_CALL)
        |=> s_call_push ##0 (pc_q == $past(instr.addr, 3));
    endproperty
    a_call: assert property (p_call)
        else $error("Call did not stack return then jump");

    property p_push;
        @(posedge mclk) disable iff (reset)
        (!busy && instr_valid && instr.op == IRB_OP_PUSH_ACC)
        |=> mem_req.wr && mem_req.addr == {IRB_STACK_PAGE, $past(sp_q)}
            && sp_q == 8'($past(sp_q) - 8'h01);
    endproperty
    a_push: assert property (p_push)
        else $error("Push order wrong");

    property p_irq_dis;
        @(posedge mclk) disable iff (reset)
        (!busy && instr_valid && instr.op == IRB_OP_SET_IRQ_DIS)
        |=> p_q[IRB_FLAG_I];
    endproperty
    a_irq_dis: assert property (p_irq_dis)
        else $error("Interrupt disable not set");

    property p_move_x;
        @(posedge mclk) disable iff (reset)
        (!busy && instr_valid && instr.op == IRB_OP_X_TO_ACC)
        |=> a_q == $past(x_q) && x_q == $past(x_q);
    endproperty
    a_move_x: assert property (p_move_x)
        else $error("X to accumulator wrong");

endmodule

// >>> dv/irb_mem_model.sv
// Memory responder standing at the far side of the unit
`timescale 1ns/1ns
module irb_mem_model
    import irb_pkg::*;
(
    input wire logic mclk,
    input wire logic reset,
    input wire irb_mem_req_type req,
    input wire logic [1:0] lat,
    output logic [7:0] rdata,
    output logic rvalid
);
    logic [7:0] mem [0:65535];
    logic [1:0] cnt_q = 2'h0;
    logic gap_q = 1'b0;
    initial begin
        rdata = 8'h00;
        rvalid = 1'b0;
    end
    // ****************
    // Read answer after lat extra cycles
    // ****************
    // Data toggles outside the answer so stale bytes never look valid
    always @(posedge mclk) begin
        rvalid <= 1'b0;
        rdata <= ~rdata;
        if (reset) begin
            cnt_q <= 2'h0;
            gap_q <= 1'b0;
        end else if (gap_q) begin
            gap_q <= 1'b0;
        end else if (req.rd) begin
            if (cnt_q == lat) begin
                rvalid <= 1'b1;
                rdata <= mem[req.addr];
                cnt_q <= 2'h0;
                gap_q <= 1'b1;
            end else begin
                cnt_q <= cnt_q + 2'h1;
            end
        end
        if (!reset && req.wr) begin
            mem[req.addr] <= req.wdata;
        end
    end
endmodule

// >>> dv/tb_index_register_branch_unit.sv
// Self-checking bench for the index register and branch unit
`timescale 1ns/1ns
module tb_index_register_branch_unit
    import irb_pkg::*;
    ;
    typedef struct {
        logic [15:0] pc;
        logic [7:0] a, x, y, s, p;
        logic [15:0] ma;
        logic [7:0] m0, m1;
        int mn;
    } irb_exp_type;
    logic mclk = 0, reset = 1, instr_valid = 0, chk = 0, busy, rvalid;
    irb_instr_type instr = '0;
    logic [1:0] lat = 2'h0;
    irb_mem_req_type mreq;
    logic [15:0] pc, epc;
    logic [7:0] rdata, acc, ix, iy, sp, st, ea, ex, ey, es, ep;
    logic [7:0] em [0:65535];
    irb_exp_type r, q[$];
    int fails = 0, checks_done = 0, cyc = 0, k;

    always #2 mclk = ~mclk;

    irb_core uut (.mclk(mclk), .reset(reset), .instr(instr),
        .instr_valid(instr_valid), .mem_rdata(rdata), .mem_rvalid(rvalid),
        .mem_req(mreq), .busy(busy), .pc(pc), .acc(acc), .index_x(ix),
        .index_y(iy), .stack_ptr(sp), .status(st));
    irb_mem_model mem_i (.mclk(mclk), .reset(reset), .req(mreq), .lat(lat),
        .rdata(rdata), .rvalid(rvalid));

    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk_reg(logic [15:0] g, logic [15:0] x);
        checks_done++;
        if (g !== x) begin
            fails++;
            $display("wrong value at %0t: reg %h not %h", $time, g, x);
        end
    endtask

    task automatic chk_mem(logic [7:0] g, logic [7:0] x);
        checks_done++;
        if (g !== x) begin
            fails++;
            $display("wrong value at %0t: byte %h not %h", $time, g, x);
        end
    endtask

    // Stack addresses wrap inside their page
    function automatic logic [15:0] below(logic [15:0] a);
        below = {a[15:8], 8'(a[7:0] - 8'h01)};
    endfunction

    // ****************
    // Result watcher
    // ****************
    always @(posedge mclk) begin
        if (chk) begin
            r = q.pop_front();
            chk_reg(pc, r.pc);
            chk_reg({8'h00, acc}, {8'h00, r.a});
            chk_reg({8'h00, ix}, {8'h00, r.x});
            chk_reg({8'h00, iy}, {8'h00, r.y});
            chk_reg({8'h00, sp}, {8'h00, r.s});
            chk_reg({8'h00, st}, {8'h00, r.p});
            if (r.mn > 0) chk_mem(mem_i.mem[r.ma], r.m0);
            if (r.mn > 1) chk_mem(mem_i.mem[below(r.ma)], r.m1);
        end
        cyc++;
        if (cyc == 20000) begin
            fails++;
            $display("wrong value at %0t: run timed out", $time);
            complete_run();
        end
    end

    function automatic void nz(logic [7:0] v);
        ep[IRB_FLAG_N] = v[7];
        ep[IRB_FLAG_Z] = (v == 8'h00);
    endfunction

    task automatic poke(logic [15:0] a);
        em[a] = 8'($urandom);
        mem_i.mem[a] = em[a];
    endtask

    task automatic note(int n, logic [15:0] a);
        q.push_back('{epc, ea, ex, ey, es, ep, a, em[a], em[below(a)], n});
        @(posedge mclk);
        chk <= 1'b1;
        @(posedge mclk);
        chk <= 1'b0;
    endtask

    task automatic do_reset;
        @(posedge mclk);
        reset <= 1'b1;
        repeat (12) @(posedge mclk);
        reset <= 1'b0;
        {epc, ea, ex, ey} = {IRB_RST_PC, IRB_RST_REG, IRB_RST_REG, IRB_RST_REG};
        {es, ep} = {IRB_RST_SP, IRB_RST_STATUS};
        note(0, 16'h0000);
    endtask

    task automatic run(irb_op_type op, logic [7:0] imm, logic [15:0] ad);
        logic isel, tk;
        logic [8:0] d;
        logic [15:0] ma, ret;
        int mn;
        isel = 1'($urandom);
        mn = 0;
        ma = {IRB_STACK_PAGE, es};
        tk = 1'b0;
        // Backdoor loads wait past the watcher's edge so they cannot race it
        @(posedge mclk);
        if (op inside {IRB_OP_PULL_ACC, IRB_OP_PULL_STATUS}) begin
            poke({IRB_STACK_PAGE, 8'(es + 8'h01)});
        end
        if (op inside {IRB_OP_INCR_MEM, IRB_OP_DECR_MEM}) poke(ad);
        if (op inside {IRB_OP_CMP_X, IRB_OP_CMP_Y} && !isel) poke(ad);
        instr <= '{op, isel, imm, ad};
        instr_valid <= 1'b1;
        lat <= 2'($urandom);
        @(posedge mclk);
        instr_valid <= 1'b0;
        #1;
        while (busy !== 1'b0) begin
            @(posedge mclk);
            #1;
        end
        epc = epc + IRB_ONE_LEN;
        ret = epc + IRB_ONE_LEN;
        case (op)
            IRB_OP_INCR_X: begin ex++; nz(ex); end
            IRB_OP_DECR_X: begin ex--; nz(ex); end
            IRB_OP_INCR_Y: begin ey++; nz(ey); end
            IRB_OP_DECR_Y: begin ey--; nz(ey); end
            IRB_OP_CMP_X, IRB_OP_CMP_Y: begin
                d = {1'b0, op == IRB_OP_CMP_X ? ex : ey};
                d = d - {1'b0, isel ? imm : em[ad]};
                ep[IRB_FLAG_C] = !d[8];
                nz(d[7:0]);
                epc = epc + (isel ? 16'h1 : 16'h2);
            end
            IRB_OP_BR_NOT_ZERO: tk = !ep[IRB_FLAG_Z];
            IRB_OP_BR_ZERO: tk = ep[IRB_FLAG_Z];
            IRB_OP_BR_CARRY_CLR: tk = !ep[IRB_FLAG_C];
            IRB_OP_BR_CARRY_SET: tk = ep[IRB_FLAG_C];
            IRB_OP_BR_MINUS: tk = ep[IRB_FLAG_N];
            IRB_OP_BR_PLUS: tk = !ep[IRB_FLAG_N];
            IRB_OP_BR_OVF_CLR: tk = !ep[IRB_FLAG_V];
            IRB_OP_BR_OVF_SET: tk = ep[IRB_FLAG_V];
            IRB_OP_CALL: begin
                {em[ma], em[below(ma)]} = ret;
                mn = 2;
                es = es - 8'h02;
                epc = ad;
            end
            IRB_OP_JUMP: epc = ad;
            IRB_OP_X_TO_ACC: begin ea = ex; nz(ea); end
            IRB_OP_SP_TO_X: begin ex = es; nz(ex); end
            IRB_OP_X_TO_SP: es = ex;
            IRB_OP_PUSH_STATUS: begin em[ma] = ep; mn = 1; es--; end
            IRB_OP_PUSH_ACC: begin em[ma] = ea; mn = 1; es--; end
            IRB_OP_PULL_STATUS: begin
                es++;
                ep = em[{IRB_STACK_PAGE, es}];
            end
            IRB_OP_PULL_ACC: begin
                es++;
                ea = em[{IRB_STACK_PAGE, es}];
                nz(ea);
            end
            IRB_OP_SET_IRQ_DIS: ep[IRB_FLAG_I] = 1'b1;
            IRB_OP_CLR_IRQ_DIS: ep[IRB_FLAG_I] = 1'b0;
            default: begin
                em[ad] = op == IRB_OP_INCR_MEM ? em[ad] + 8'h01 : em[ad] - 8'h01;
                nz(em[ad]);
                ma = ad;
                mn = 1;
                epc = epc + 16'h2;
            end
        endcase
        if (op inside {[IRB_OP_BR_NOT_ZERO:IRB_OP_BR_OVF_SET]}) begin
            epc = epc + 16'h1 + (tk ? {{8{imm[7]}}, imm} : 16'h0);
        end
        note(mn, ma);
    endtask

    initial begin
        k = $urandom(32'h34814DD5);
        do_reset();
        run(IRB_OP_DECR_X, 8'h00, 16'h0000);
        run(IRB_OP_INCR_X, 8'h00, 16'h0000);
        run(IRB_OP_DECR_Y, 8'h00, 16'h0000);
        run(IRB_OP_INCR_Y, 8'h00, 16'h0000);
        $display("test index wrap done");
        // Offsets lean on the signed extremes, the awkward reach
        repeat (300) begin
            k = $urandom_range(0, 3);
            run(irb_op_type'(5'($urandom_range(1, 27))),
                k == 0 ? 8'h80 : k == 1 ? 8'h7F : 8'($urandom),
                16'($urandom));
        end
        $display("test random mix done");
        do_reset();
        run(IRB_OP_SET_IRQ_DIS, 8'h00, 16'h0000);
        run(IRB_OP_CLR_IRQ_DIS, 8'h00, 16'h0000);
        $display("test second reset done");
        complete_run();
    end
endmodule

// >>> shared/irb_pkg.sv
// Shared types and constants for the index register and branch unit
package irb_pkg;

    localparam logic [7:0] IRB_BYTE_MAX = 8'hFF;
    localparam logic [7:0] IRB_RST_REG = 8'h00;
    localparam logic [7:0] IRB_RST_SP = 8'hFF;
    localparam logic [15:0] IRB_RST_PC = 16'h0000;
    localparam logic [7:0] IRB_STACK_PAGE = 8'h01;
    localparam logic [7:0] IRB_RST_STATUS = 8'h20;
    // Status bit positions
    localparam int IRB_FLAG_C = 0;
    localparam int IRB_FLAG_Z = 1;
    localparam int IRB_FLAG_I = 2;
    localparam int IRB_FLAG_V = 6;
    localparam int IRB_FLAG_N = 7;
    localparam logic [15:0] IRB_BRANCH_LEN = 16'h0002;
    localparam logic [15:0] IRB_CALL_LEN = 16'h0003;
    localparam logic [15:0] IRB_ONE_LEN = 16'h0001;

    typedef enum logic [4:0] {
        IRB_OP_NOP,
        IRB_OP_INCR_X,
        IRB_OP_DECR_X,
        IRB_OP_INCR_Y,
        IRB_OP_DECR_Y,
        IRB_OP_CMP_X,
        IRB_OP_CMP_Y,
        IRB_OP_BR_NOT_ZERO,
        IRB_OP_BR_ZERO,
        IRB_OP_BR_CARRY_CLR,
        IRB_OP_BR_CARRY_SET,
        IRB_OP_BR_MINUS,
        IRB_OP_BR_PLUS,
        IRB_OP_BR_OVF_CLR,
        IRB_OP_BR_OVF_SET,
        IRB_OP_CALL,
        IRB_OP_JUMP,
        IRB_OP_X_TO_ACC,
        IRB_OP_SP_TO_X,
        IRB_OP_X_TO_SP,
        IRB_OP_PUSH_STATUS,
        IRB_OP_PULL_STATUS,
        IRB_OP_PUSH_ACC,
        IRB_OP_PULL_ACC,
        IRB_OP_SET_IRQ_DIS,
        IRB_OP_CLR_IRQ_DIS,
        IRB_OP_INCR_MEM,
        IRB_OP_DECR_MEM
    } irb_op_type;

    // One decoded instruction from program memory
    typedef struct packed {
        irb_op_type op;
        logic imm_sel;
        logic [7:0] imm;
        logic [15:0] addr;
    } irb_instr_type;

    // One memory access request
    typedef struct packed {
        logic rd;
        logic wr;
        logic [15:0] addr;
        logic [7:0] wdata;
    } irb_mem_req_type;

endpackage
